/* File: verilog/gpb_cfg.svh */
`ifndef GPB_CFG_SVH
`define GPB_CFG_SVH
// Register byte offsets
`define GPB_OFS_CFG_LOW  8'h00
`define GPB_OFS_CFG_HIGH 8'h04
`define GPB_OFS_IN_LVL   8'h08
`define GPB_OFS_OUT_LVL  8'h0C
`define GPB_OFS_SET_CLR  8'h10
`define GPB_OFS_CLR_ONLY 8'h14
// Reset values
`define GPB_CFG_RST      32'h44444444
`define GPB_OUT_RST      16'h0000
// Field layout
`define GPB_NPINS        16
`define GPB_SLICE_W      4
`define GPB_MODE_LSB     0
`define GPB_FUNC_LSB     2
`define GPB_CLR_LSB      16
`define GPB_STRB_WORD    4'hF
`endif

/* File: verilog/gpb_pkg.sv */
`include "gpb_cfg.svh"
package gpb_pkg;
  typedef enum logic [1:0] {
    GPB_MODE_INPUT   = 2'h0,
    GPB_MODE_OUT_10M = 2'h1,
    GPB_MODE_OUT_2M  = 2'h2,
    GPB_MODE_OUT_50M = 2'h3
  } gpb_mode_t;
  typedef enum logic [1:0] {
    GPB_FN_ANALOG = 2'h0,
    GPB_FN_FLOAT  = 2'h1,
    GPB_FN_PULL   = 2'h2,
    GPB_FN_RSVD   = 2'h3
  } gpb_in_fn_t;
  typedef enum logic [2:0] {
    GPB_REG_CFG_LOW  = 3'h0,
    GPB_REG_CFG_HIGH = 3'h1,
    GPB_REG_IN_LVL   = 3'h2,
    GPB_REG_OUT_LVL  = 3'h3,
    GPB_REG_SET_CLR  = 3'h4,
    GPB_REG_CLR_ONLY = 3'h5,
    GPB_REG_NONE     = 3'h7
  } gpb_reg_t;
  typedef struct packed {
    logic drive;
    logic odrain;
    logic periph;
    logic analog;
    logic pull;
  } gpb_pin_mode_t;
  // Full byte address compare, so misaligned addresses fall to none
  function automatic gpb_reg_t gpb_decode_addr(input logic [7:0] a);
    if (a == `GPB_OFS_CFG_LOW) return GPB_REG_CFG_LOW;
    else if (a == `GPB_OFS_CFG_HIGH) return GPB_REG_CFG_HIGH;
    else if (a == `GPB_OFS_IN_LVL) return GPB_REG_IN_LVL;
    else if (a == `GPB_OFS_OUT_LVL) return GPB_REG_OUT_LVL;
    else if (a == `GPB_OFS_SET_CLR) return GPB_REG_SET_CLR;
    else if (a == `GPB_OFS_CLR_ONLY) return GPB_REG_CLR_ONLY;
    else return GPB_REG_NONE;
  endfunction
  // Mode in low two bits, function in upper two
  function automatic gpb_pin_mode_t gpb_decode_pin(input logic [3:0] s);
    gpb_pin_mode_t r;
    logic [1:0]    m;
    logic [1:0]    f;
    m = s[`GPB_MODE_LSB +: 2];
    f = s[`GPB_FUNC_LSB +: 2];
    r.drive  = (m != GPB_MODE_INPUT);
    r.analog = !r.drive && (f == GPB_FN_ANALOG);
    r.pull   = !r.drive && (f == GPB_FN_PULL);
    r.periph = r.drive && f[1];
    r.odrain = r.drive && f[0];
    return r;
  endfunction
endpackage

/* File: verilog/gpb_pin_if.sv */
`timescale 1ns/1ps
interface gpb_pin_if;
  logic [31:0] cfg_low;
  logic [31:0] cfg_high;
  logic [15:0] out_level;
  logic [15:0] in_level;
  modport regs (output cfg_low, output cfg_high, output out_level, input in_level);
  modport pins (input cfg_low, input cfg_high, input out_level, output in_level);
endinterface

/* File: verilog/gpb_pin_bank.sv */
`timescale 1ns/1ps
`include "gpb_cfg.svh"
module gpb_pin_bank (
  input  logic        clk,
  input  logic        rst_n,
  gpb_pin_if.pins     pif,
  input  logic [15:0] pin_in,
  input  logic [15:0] af_out,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  output logic [15:0] pin_pull_up_en,
  output logic [15:0] pin_pull_dn_en,
  output logic [15:0] pin_analog_en,
  output logic [31:0] pin_speed
);
  logic [15:0] sync1_ff, sync2_ff, in_level_ff, nxt_in_level;
  logic [15:0] out_ff, oe_ff, pu_ff, pd_ff, an_ff;
  logic [15:0] nxt_out, nxt_oe, nxt_pu, nxt_pd, nxt_an;
  logic [15:0] in_mode_c, od_c;
  logic [31:0] speed_ff, nxt_speed;

  // Per-pin decode of the 4-bit slices into drive and sample values
  always_comb begin
    logic [3:0] s;
    gpb_pkg::gpb_pin_mode_t p;
    logic lvl;
    s = 4'h0;
    p = '0;
    lvl = 1'b0;
    nxt_out = 16'h0000;
    nxt_oe = 16'h0000;
    nxt_pu = 16'h0000;
    nxt_pd = 16'h0000;
    nxt_an = 16'h0000;
    nxt_in_level = 16'h0000;
    in_mode_c = 16'h0000;
    od_c = 16'h0000;
    nxt_speed = 32'h0000_0000;
    for (int i = 0; i < `GPB_NPINS; i++) begin
      s = (i < 8) ? pif.cfg_low[i*4 +: 4] : pif.cfg_high[(i-8)*4 +: 4];
      p = gpb_pkg::gpb_decode_pin(s);
      lvl = p.periph ? af_out[i] : pif.out_level[i];
      in_mode_c[i] = !p.drive;
      od_c[i] = p.odrain;
      // Open-drain only pulls low and releases for a high level
      nxt_oe[i] = p.drive && !(p.odrain && lvl);
      nxt_out[i] = lvl && !p.odrain;
      nxt_pu[i] = p.pull && pif.out_level[i];
      nxt_pd[i] = p.pull && !pif.out_level[i];
      nxt_an[i] = p.analog;
      nxt_speed[i*2 +: 2] = s[`GPB_MODE_LSB +: 2];
      nxt_in_level[i] = p.analog ? 1'b0 : sync2_ff[i];
    end
  end

  // Two-stage synchroniser, sampler and registered pad controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 16'h0000;
      sync2_ff <= 16'h0000;
      in_level_ff <= 16'h0000;
      out_ff <= 16'h0000;
      oe_ff <= 16'h0000;
      pu_ff <= 16'h0000;
      pd_ff <= 16'h0000;
      an_ff <= 16'h0000;
      speed_ff <= 32'h0000_0000;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      in_level_ff <= nxt_in_level;
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      pu_ff <= nxt_pu;
      pd_ff <= nxt_pd;
      an_ff <= nxt_an;
      speed_ff <= nxt_speed;
    end
  end

  assign pif.in_level = in_level_ff;
  assign pin_out = out_ff;
  assign pin_oe = oe_ff;
  assign pin_pull_up_en = pu_ff;
  assign pin_pull_dn_en = pd_ff;
  assign pin_analog_en = an_ff;
  assign pin_speed = speed_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Pad and sampler checks
  a_analog_reads_zero: assert property ((in_level_ff & $past(nxt_an)) == 16'h0000)
    else $error("analog pin sampled nonzero");
  a_sample_follows: assert property (((in_level_ff ^ $past(sync2_ff)) & ~$past(nxt_an)) == 16'h0000)
    else $error("input level not sampled from pin");
  a_input_no_drive: assert property ((pin_oe & $past(in_mode_c)) == 16'h0000)
    else $error("input pin driven");
  a_odrain_no_high: assert property ((pin_oe & pin_out & $past(od_c)) == 16'h0000)
    else $error("open-drain pin drove high");
  c_odrain_release: cover property ((od_c != 16'h0000) ##1 ((~pin_oe & $past(od_c)) != 16'h0000));
endmodule // gpb_pin_bank

/* File: verilog/gpb_port_regs.sv */
`timescale 1ns/1ps
`include "gpb_cfg.svh"
// What this block does
// - Each pin owns a 4-bit slice, pins 0-7 in the low config word and 8-15 in the high one.
// - Mode 00 is input, 01 output at 10 MHz, 10 output at 2 MHz, 11 output at 50 MHz.
// - In input mode function 00 is analog, 01 floating, 10 pull-up/pull-down, 11 reserved.
// - In output mode function selects general or peripheral source, push-pull or open-drain.
// - Both config words reset to all pins floating input.
// - The input-level word shows the sampled pins in bits 15:0, upper bits read zero.
// - The output-level word is 16-bit read/write, resets to zero and drives general outputs.
// - Ones in set/clear bits 15:0 set the matching output bits.
// - Ones in set/clear bits 31:16 clear the output bit sixteen lower.
// - When one write both sets and clears a pin, the set wins.
// - The clear-only word clears output bits where bits 15:0 are one; upper bits do nothing.
// - Input levels are resampled from the pins on every clock cycle.
// - A pin in analog mode always reads zero in the input-level word.
module gpb_port_regs (
  input  logic        clk,
  input  logic        rst_n,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  input  logic [3:0]  pstrb,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  logic [15:0] pin_in,
  input  logic [15:0] af_out,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  output logic [15:0] pin_pull_up_en,
  output logic [15:0] pin_pull_dn_en,
  output logic [15:0] pin_analog_en,
  output logic [31:0] pin_speed,
  output logic [15:0] periph_in_level
);
  gpb_pkg::gpb_reg_t reg_sel;
  logic              acc;
  logic              setup_rd;
  logic              full_word;
  logic              wr_ok;
  logic [31:0]       cfg_low_ff, nxt_cfg_low;
  logic [31:0]       cfg_high_ff, nxt_cfg_high;
  logic [15:0]       out_level_ff, nxt_out_level;
  logic [31:0]       prdata_ff, nxt_prdata;

  gpb_pin_if pif ();

  // Bus phase decode
  assign reg_sel = gpb_pkg::gpb_decode_addr(paddr);
  assign acc = psel && penable;
  assign setup_rd = psel && !penable && !pwrite;
  assign full_word = (pstrb == `GPB_STRB_WORD);
  assign wr_ok = acc && pwrite && full_word && (reg_sel != gpb_pkg::GPB_REG_NONE);

  // Zero wait states; error on an unmapped address or a partial-strobe write
  assign pready = 1'b1;
  assign pslverr = acc && ((reg_sel == gpb_pkg::GPB_REG_NONE) || (pwrite && !full_word));

  // Register writes; a write to the input-level word is silently dropped
  always_comb begin
    nxt_cfg_low = cfg_low_ff;
    nxt_cfg_high = cfg_high_ff;
    nxt_out_level = out_level_ff;
    if (wr_ok) begin
      if (reg_sel == gpb_pkg::GPB_REG_CFG_LOW) begin
        nxt_cfg_low = pwdata;
      end else if (reg_sel == gpb_pkg::GPB_REG_CFG_HIGH) begin
        nxt_cfg_high = pwdata;
      end else if (reg_sel == gpb_pkg::GPB_REG_OUT_LVL) begin
        nxt_out_level = pwdata[15:0];
      end else if (reg_sel == gpb_pkg::GPB_REG_SET_CLR) begin
        // Clear first, then set, so a set in the same word wins
        nxt_out_level = (out_level_ff & ~pwdata[`GPB_CLR_LSB +: 16]) | pwdata[15:0];
      end else if (reg_sel == gpb_pkg::GPB_REG_CLR_ONLY) begin
        nxt_out_level = out_level_ff & ~pwdata[15:0];
      end
    end
  end

  // Read data is captured in the setup phase so it comes from a flop
  always_comb begin
    nxt_prdata = prdata_ff;
    if (setup_rd) begin
      if (reg_sel == gpb_pkg::GPB_REG_CFG_LOW) begin
        nxt_prdata = cfg_low_ff;
      end else if (reg_sel == gpb_pkg::GPB_REG_CFG_HIGH) begin
        nxt_prdata = cfg_high_ff;
      end else if (reg_sel == gpb_pkg::GPB_REG_IN_LVL) begin
        nxt_prdata = {16'h0000, pif.in_level};
      end else if (reg_sel == gpb_pkg::GPB_REG_OUT_LVL) begin
        nxt_prdata = {16'h0000, out_level_ff};
      end else begin
        nxt_prdata = 32'h0000_0000;
      end
    end
  end

  // Register state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_low_ff <= `GPB_CFG_RST;
      cfg_high_ff <= `GPB_CFG_RST;
      out_level_ff <= `GPB_OUT_RST;
      prdata_ff <= 32'h0000_0000;
    end else begin
      cfg_low_ff <= nxt_cfg_low;
      cfg_high_ff <= nxt_cfg_high;
      out_level_ff <= nxt_out_level;
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;
  assign periph_in_level = pif.in_level;
  assign pif.cfg_low = cfg_low_ff;
  assign pif.cfg_high = cfg_high_ff;
  assign pif.out_level = out_level_ff;

  // Pad side: sampling, analog forcing and drive control
  gpb_pin_bank u_pins (
    .clk            (clk),
    .rst_n          (rst_n),
    .pif            (pif.pins),
    .pin_in         (pin_in),
    .af_out         (af_out),
    .pin_out        (pin_out),
    .pin_oe         (pin_oe),
    .pin_pull_up_en (pin_pull_up_en),
    .pin_pull_dn_en (pin_pull_dn_en),
    .pin_analog_en  (pin_analog_en),
    .pin_speed      (pin_speed)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Register behaviour checks
  a_cfg_reset_val: assert property ($rose(rst_n) |->
      (cfg_low_ff == `GPB_CFG_RST) && (cfg_high_ff == `GPB_CFG_RST) && (out_level_ff == `GPB_OUT_RST))
    else $error("config reset value wrong");
  a_partial_refused: assert property (acc && pwrite && !full_word |=>
      $stable(cfg_low_ff) && $stable(cfg_high_ff) && $stable(out_level_ff))
    else $error("partial write changed state");
  a_out_write: assert property (wr_ok && reg_sel == gpb_pkg::GPB_REG_OUT_LVL |=>
      out_level_ff == $past(pwdata[15:0]))
    else $error("output level write lost");
  a_set_wins: assert property (wr_ok && reg_sel == gpb_pkg::GPB_REG_SET_CLR |=>
      (out_level_ff & $past(pwdata[15:0])) == $past(pwdata[15:0]))
    else $error("set bit not applied");
  a_clear_applies: assert property (wr_ok && reg_sel == gpb_pkg::GPB_REG_SET_CLR |=>
      (out_level_ff & $past(pwdata[31:16]) & ~$past(pwdata[15:0])) == 16'h0000)
    else $error("clear bit not applied");
  a_keep_others: assert property (wr_ok && reg_sel == gpb_pkg::GPB_REG_SET_CLR |=>
      ((out_level_ff ^ $past(out_level_ff)) & ~$past(pwdata[31:16]) & ~$past(pwdata[15:0])) == 16'h0000)
    else $error("untouched output bit changed");
  a_clear_only: assert property (wr_ok && reg_sel == gpb_pkg::GPB_REG_CLR_ONLY |=>
      out_level_ff == ($past(out_level_ff) & ~$past(pwdata[15:0])))
    else $error("clear-only write wrong");
  a_in_upper_zero: assert property (setup_rd && reg_sel == gpb_pkg::GPB_REG_IN_LVL |=>
      prdata[31:16] == 16'h0000 && prdata[15:0] == $past(pif.in_level))
    else $error("input level read wrong");
  a_wo_read_zero: assert property (setup_rd &&
      (reg_sel == gpb_pkg::GPB_REG_SET_CLR || reg_sel == gpb_pkg::GPB_REG_CLR_ONLY) |=> prdata == 32'h0000_0000)
    else $error("write-only word read nonzero");

  c_set_clear_same: cover property (wr_ok && reg_sel == gpb_pkg::GPB_REG_SET_CLR &&
      (pwdata[15:0] & pwdata[31:16]) != 16'h0000);
  c_partial_write: cover property (acc && pwrite && !full_word);
  // Pad enables follow one edge after the config word, so look two edges on
  c_cfg_to_output: cover property (wr_ok && reg_sel == gpb_pkg::GPB_REG_CFG_LOW ##2 pin_oe != 16'h0000);
endmodule // gpb_port_regs

/* File: testbench/gpb_pad_model.sv */
`timescale 1ns/1ps
// Pads and on-chip peripheral outputs as seen from outside the port
module gpb_pad_model (
  input  logic        clk,
  input  logic [15:0] pin_out,
  input  logic [15:0] pin_oe,
  input  logic [15:0] pin_pull_up_en,
  input  logic [15:0] pin_pull_dn_en,
  input  logic [15:0] ext_drv,
  input  logic [15:0] ext_val,
  input  logic [15:0] af_val,
  output logic [15:0] pin_in,
  output logic [15:0] af_out
);
  logic [15:0] flt_ff = 16'h5555;
  // An undriven pad wanders every cycle so a stale level never passes as valid
  always @(posedge clk) begin
    flt_ff <= ~flt_ff;
  end
  // Port drive first, then the outside driver, then the weak pulls
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_drv[i]) pin_in[i] = ext_val[i];
      else if (pin_pull_up_en[i]) pin_in[i] = 1'b1;
      else if (pin_pull_dn_en[i]) pin_in[i] = 1'b0;
      else pin_in[i] = flt_ff[i];
    end
  end
  assign af_out = af_val; // Peripheral levels are synchronous to clk
endmodule // gpb_pad_model

/* File: testbench/test_gpb_port_regs.sv */
`timescale 1ns/1ps
module test_gpb_port_regs;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, pin_speed;
  logic [3:0]  pstrb;
  logic [15:0] pin_in, af_out, pin_out, pin_oe, pull_up, pull_dn, analog_en, periph_in;
  logic [15:0] ext_drv, ext_val, af_val;
  logic [31:0] rdv;
  logic        err;
  int          mismatches, checks, cyc;

  gpb_port_regs gpb_port_regs_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .af_out(af_out), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull_up_en(pull_up), .pin_pull_dn_en(pull_dn),
    .pin_analog_en(analog_en), .pin_speed(pin_speed), .periph_in_level(periph_in));
  gpb_pad_model gpb_pad_model_i (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull_up_en(pull_up), .pin_pull_dn_en(pull_dn), .ext_drv(ext_drv),
    .ext_val(ext_val), .af_val(af_val), .pin_in(pin_in), .af_out(af_out));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; request held until the access edge, where the answer is taken
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Whole-word accesses only
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF, rdv, err);
    chk("write error", 32'h0, {31'h0, err});
    chk("ready", 32'h1, {31'h0, pready});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0, 4'hF, rdv, err);
    chk(name, exp, rdv);
  endtask

  // Let register updates reach the pads, then sample off the edge
  task automatic settle;
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic t_reset_values;
    rd(8'h00, 32'h44444444, "config low");
    rd(8'h04, 32'h44444444, "config high");
    rd(8'h0C, 32'h00000000, "output levels");
    rd(8'h10, 32'h00000000, "set clear read");
    rd(8'h14, 32'h00000000, "clear only read");
    chk("oe after reset", 32'h0, {16'h0, pin_oe});
  endtask

  task automatic t_modes;
    af_val <= 16'h0004;
    wr(8'h00, 32'h4444DB61);
    wr(8'h04, 32'h44444443);
    wr(8'h0C, 32'h00000003);
    rd(8'h00, 32'h4444DB61, "config low back");
    settle();
    chk("speed", 32'h00030079, pin_speed);
    chk("oe", 32'h0000010D, {16'h0, pin_oe});
    chk("out", 32'h00000005, {16'h0, pin_out & 16'h010F});
    af_val <= 16'h0008;
    settle();
    chk("periph oe", 32'h00000105, {16'h0, pin_oe});
    wr(8'h00, 32'h44444444);
    wr(8'h04, 32'h44444444);
  endtask

  task automatic t_set_clear;
    wr(8'h0C, 32'hFFFF00F0);
    rd(8'h0C, 32'h000000F0, "out upper bits");
    wr(8'h10, 32'h00030081);
    rd(8'h0C, 32'h000000F1, "after set clear");
    wr(8'h10, 32'h00800000);
    rd(8'h0C, 32'h00000071, "after clear high");
    wr(8'h14, 32'hFFFF0030);
    rd(8'h0C, 32'h00000041, "after clear only");
  endtask

  task automatic t_inputs;
    ext_drv <= 16'hFFFF;
    ext_val <= 16'hA5C3;
    settle();
    rd(8'h08, 32'h0000A5C3, "input levels");
    ext_val <= 16'h5A3C;
    settle();
    rd(8'h08, 32'h00005A3C, "input follows");
    wr(8'h0C, 32'h00000002);
    // Pin 0 analog, pins 1 and 2 pulled: up and down by their output bits
    wr(8'h00, 32'h44444880);
    ext_drv <= 16'hFFF9;
    settle();
    chk("analog en", 32'h1, {16'h0, analog_en} & 32'h7);
    chk("pull up", 32'h2, {16'h0, pull_up} & 32'h7);
    chk("pull down", 32'h4, {16'h0, pull_dn} & 32'h7);
    chk("periph in", 32'h00005A3A, {16'h0, periph_in});
    rd(8'h08, 32'h00005A3A, "analog and pulled");
    wr(8'h00, 32'h44444444);
    // Drive every pad again, a floating one would wander in the next scenario
    ext_drv <= 16'hFFFF;
  endtask

  task automatic t_refused;
    apb(1'b1, 8'h0C, 32'h0000FFFF, 4'h3, rdv, err);
    chk("partial strobe error", 32'h1, {31'h0, err});
    rd(8'h0C, 32'h00000002, "out after partial");
    apb(1'b0, 8'h18, 32'h0, 4'hF, rdv, err);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rdv);
    wr(8'h08, 32'h0000FFFF);
    rd(8'h08, 32'h00005A3C, "input write ignored");
  endtask

  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pstrb   = 4'hF;
    ext_drv = 16'h0000;
    ext_val = 16'h0000;
    af_val  = 16'h0000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_modes();
    t_set_clear();
    t_inputs();
    t_refused();
    report_and_stop();
  end
endmodule // test_gpb_port_regs
